/* hdl/logic_cell_defs.svh */
// Operation
// - Two sixteen-entry four-input primary tables
// - Three-input combining table, any function
// - Two combiner inputs selectable, one fixed
// - Tables combine into any five-input function
// - Chained tables give some nine-input functions
// - Three independent functions produced at once
// - Four-input plus some six-input functions
// - Two registered function outputs plus two registered storage outputs
// - Contents held in rewritable configuration storage
// - Configuration fetched serially or written externally
// - Output one picks A or combiner
// - Storage inputs picked four ways
// - Combiner inputs: preset/clear, control, direct
`ifndef LOGIC_CELL_DEFS_SVH
`define LOGIC_CELL_DEFS_SVH
`define PRIMARY_TABLE_BITS 16
`define COMBINING_TABLE_BITS 8
`define CFG_TABLE_A_POS 0
`define CFG_TABLE_B_POS 16
`define CFG_COMBINER_POS 32
`define CFG_SEL_IN1_POS 40
`define CFG_SEL_IN2_POS 41
`define CFG_OUT_X_POS 42
`define CFG_OUT_Y_POS 43
`define CFG_STORE_X_POS 44
`define CFG_STORE_Y_POS 46
`define CFG_TOTAL_BITS 48
`define CFG_RESET_VALUE 48'h0
`endif

/* hdl/logic_cell_pkg.sv */
package logic_cell_pkg;
    typedef enum logic [1:0] {
        SRC_TABLE_A = 2'h0,
        SRC_TABLE_B = 2'h1,
        SRC_COMBINER = 2'h2,
        SRC_DIRECT = 2'h3
    } store_src_e;
    typedef enum logic [2:0] {
        LOAD_IDLE = 3'h1,
        LOAD_SHIFT = 3'h2,
        LOAD_DONE = 3'h4
    } load_state_e;
endpackage : logic_cell_pkg

/* hdl/lookup_table.sv */
`timescale 1ns/1ns
module lookup_table #(
    parameter int WIDTH = 4
) (
    input wire logic [(1 << WIDTH) - 1:0] contents_i,
    input wire logic [WIDTH - 1:0] addr_i,
    output logic data_o
);
    // Input zero sits in bit 0 of the address
    assign data_o = contents_i[addr_i];
endmodule : lookup_table

/* hdl/logic_cell.sv */
`timescale 1ns/1ns
`include "logic_cell_defs.svh"
module logic_cell (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CFG_LOAD_I,
    input wire logic CFG_EXTERNAL_I,
    input wire logic CFG_DATA_I,
    input wire logic CFG_VALID_I,
    input wire logic [3:0] TABLE_A_INPUTS_I,
    input wire logic [3:0] TABLE_B_INPUTS_I,
    input wire logic PRESET_CLEAR_LINE_I,
    input wire logic COMBINER_INPUT_ONE_I,
    input wire logic DIRECT_IN_I,
    output logic CFG_FETCH_O,
    output logic CFG_DONE_O,
    output logic OUT_X_O,
    output logic OUT_Y_O,
    output logic STORE_X_O,
    output logic STORE_Y_O
);
    import logic_cell_pkg::*;

    typedef struct packed {
        load_state_e state;
        logic [5:0] count;
        logic [`CFG_TOTAL_BITS-1:0] shift;
        logic [`CFG_TOTAL_BITS-1:0] cfg;
        logic fetch;
        logic done;
        logic out_x;
        logic out_y;
        logic store_x;
        logic store_y;
    } cell_s;

    cell_s st_r;
    cell_s st_nxt;
    logic a_out;
    logic b_out;
    logic h_out;
    logic h_in1;
    logic h_in2;

    function automatic logic pick_store(input logic [1:0] sel, input logic a,
                                        input logic b, input logic h, input logic d);
        case (sel)
            SRC_TABLE_A: pick_store = a;
            SRC_TABLE_B: pick_store = b;
            SRC_COMBINER: pick_store = h;
            default: pick_store = d;
        endcase
    endfunction : pick_store

    // Two independent four-input tables
    lookup_table #(.WIDTH(4)) u_table_a (
        .contents_i(st_r.cfg[`CFG_TABLE_A_POS +: `PRIMARY_TABLE_BITS]),
        .addr_i(TABLE_A_INPUTS_I),
        .data_o(a_out)
    );
    lookup_table #(.WIDTH(4)) u_table_b (
        .contents_i(st_r.cfg[`CFG_TABLE_B_POS +: `PRIMARY_TABLE_BITS]),
        .addr_i(TABLE_B_INPUTS_I),
        .data_o(b_out)
    );

    // Combiner inputs 1 and 2 selectable; input 0 always preset/clear line
    assign h_in1 = st_r.cfg[`CFG_SEL_IN1_POS] ? a_out : COMBINER_INPUT_ONE_I;
    assign h_in2 = st_r.cfg[`CFG_SEL_IN2_POS] ? b_out : DIRECT_IN_I;

    // Chaining both tables gives five-input and wider functions
    lookup_table #(.WIDTH(3)) u_combiner (
        .contents_i(st_r.cfg[`CFG_COMBINER_POS +: `COMBINING_TABLE_BITS]),
        .addr_i({h_in2, h_in1, PRESET_CLEAR_LINE_I}),
        .data_o(h_out)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.fetch = 1'b0;
        case (st_r.state)
            LOAD_IDLE: begin
                if (CFG_LOAD_I) begin
                    st_nxt.state = LOAD_SHIFT;
                    st_nxt.count = 6'h0;
                    st_nxt.done = 1'b0;
                    st_nxt.fetch = ~CFG_EXTERNAL_I;
                end
            end
            LOAD_SHIFT: begin
                // Master mode requests each bit; slave mode takes valid bits
                st_nxt.fetch = ~CFG_EXTERNAL_I;
                if (CFG_VALID_I) begin
                    st_nxt.shift = {CFG_DATA_I, st_r.shift[`CFG_TOTAL_BITS-1:1]};
                    st_nxt.count = st_r.count + 6'h1;
                    if (st_r.count == 6'(`CFG_TOTAL_BITS - 1)) begin
                        st_nxt.state = LOAD_DONE;
                        st_nxt.fetch = 1'b0;
                    end
                end
            end
            LOAD_DONE: begin
                st_nxt.cfg = st_r.shift;
                st_nxt.done = 1'b1;
                st_nxt.state = LOAD_IDLE;
            end
            default: st_nxt.state = LOAD_IDLE;
        endcase
        // Four registered results leave: outputs X and Y plus both storage paths
        st_nxt.out_x = st_r.cfg[`CFG_OUT_X_POS] ? h_out : a_out;
        st_nxt.out_y = st_r.cfg[`CFG_OUT_Y_POS] ? h_out : b_out;
        st_nxt.store_x = pick_store(st_r.cfg[`CFG_STORE_X_POS +: 2], a_out, b_out,
                                    h_out, DIRECT_IN_I);
        st_nxt.store_y = pick_store(st_r.cfg[`CFG_STORE_Y_POS +: 2], a_out, b_out,
                                    h_out, DIRECT_IN_I);
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_r <= '{state: LOAD_IDLE, count: 6'h0, shift: `CFG_RESET_VALUE,
                      cfg: `CFG_RESET_VALUE, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign CFG_FETCH_O = st_r.fetch;
    assign CFG_DONE_O = st_r.done;
    assign OUT_X_O = st_r.out_x;
    assign OUT_Y_O = st_r.out_y;
    assign STORE_X_O = st_r.store_x;
    assign STORE_Y_O = st_r.store_y;

    property p_out_x;
        @(posedge CLK_I) disable iff (!RESETN_I)
        OUT_X_O == $past(st_r.cfg[`CFG_OUT_X_POS] ? h_out : a_out);
    endproperty
    a_out_x_sel: assert property (p_out_x) else $error("output X select wrong");
    a_out_y_sel: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        OUT_Y_O == $past(st_r.cfg[`CFG_OUT_Y_POS] ? h_out : b_out))
        else $error("output Y select wrong");
    a_table_a_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        a_out == st_r.cfg[`CFG_TABLE_A_POS + 32'(TABLE_A_INPUTS_I)])
        else $error("table A read wrong");
    a_table_b_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        b_out == st_r.cfg[`CFG_TABLE_B_POS + 32'(TABLE_B_INPUTS_I)])
        else $error("table B read wrong");
    a_combiner_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        h_out == st_r.cfg[`CFG_COMBINER_POS + 32'({h_in2, h_in1, PRESET_CLEAR_LINE_I})])
        else $error("combiner read wrong");
    a_combiner_in1: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !st_r.cfg[`CFG_SEL_IN1_POS] |-> h_in1 == COMBINER_INPUT_ONE_I)
        else $error("combiner input one wrong");
    a_store_direct: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_STORE_X_POS +: 2] == 2'h3 && $stable(st_r.cfg) |=>
        STORE_X_O == $past(DIRECT_IN_I))
        else $error("storage direct path wrong");
    a_load_done: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_DONE |=> CFG_DONE_O && st_r.cfg == $past(st_r.shift))
        else $error("configuration not applied");
    a_slave_nofetch: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && CFG_EXTERNAL_I |=> !CFG_FETCH_O)
        else $error("fetch in slave mode");

    // Load sequencing: the applied image moves only in the apply state
    property p_cfg_hold;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state != LOAD_DONE |=> $stable(st_r.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration moved outside apply");

    property p_done_clear;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_IDLE && CFG_LOAD_I |=> !CFG_DONE_O && st_r.state == LOAD_SHIFT;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("load start not taken");

    property p_done_idle;
        @(posedge CLK_I) disable iff (!RESETN_I)
        CFG_DONE_O |-> st_r.state == LOAD_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("done flag outside idle");

    property p_apply_once;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_DONE |=> st_r.state == LOAD_IDLE;
    endproperty
    a_apply_once: assert property (p_apply_once)
        else $error("apply state held too long");

    property p_state_onehot;
        @(posedge CLK_I) disable iff (!RESETN_I)
        $onehot(st_r.state);
    endproperty
    a_state_onehot: assert property (p_state_onehot)
        else $error("load state not one-hot");

    property p_fetch_master;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && !CFG_EXTERNAL_I
        && !(CFG_VALID_I && st_r.count == 6'(`CFG_TOTAL_BITS - 1)) |=> CFG_FETCH_O;
    endproperty
    a_fetch_master: assert property (p_fetch_master)
        else $error("fetch dropped in master load");

    property p_fetch_shift;
        @(posedge CLK_I) disable iff (!RESETN_I)
        CFG_FETCH_O |-> st_r.state == LOAD_SHIFT;
    endproperty
    a_fetch_shift: assert property (p_fetch_shift)
        else $error("fetch outside shift state");

    property p_bit_take;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && CFG_VALID_I
        |=> st_r.shift[`CFG_TOTAL_BITS-1] == $past(CFG_DATA_I);
    endproperty
    a_bit_take: assert property (p_bit_take)
        else $error("serial bit not captured");

    property p_bit_count;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && CFG_VALID_I |=> st_r.count == $past(st_r.count) + 6'h1;
    endproperty
    a_bit_count: assert property (p_bit_count)
        else $error("bit count not advanced");

    property p_bit_wait;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && !CFG_VALID_I
        |=> st_r.state == LOAD_SHIFT && $stable(st_r.shift);
    endproperty
    a_bit_wait: assert property (p_bit_wait)
        else $error("shift moved without valid bit");

    property p_last_bit;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_SHIFT && CFG_VALID_I && st_r.count == 6'(`CFG_TOTAL_BITS - 1)
        |=> st_r.state == LOAD_DONE;
    endproperty
    a_last_bit: assert property (p_last_bit)
        else $error("last bit did not end shift");

    property p_load_count;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.state == LOAD_IDLE && CFG_LOAD_I |=> st_r.count == 6'h0;
    endproperty
    a_load_count: assert property (p_load_count)
        else $error("bit count not cleared at load");

    // Combiner steering
    property p_combiner_in2;
        @(posedge CLK_I) disable iff (!RESETN_I)
        !st_r.cfg[`CFG_SEL_IN2_POS] |-> h_in2 == DIRECT_IN_I;
    endproperty
    a_combiner_in2: assert property (p_combiner_in2)
        else $error("combiner input two wrong");

    property p_chain_in1;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_SEL_IN1_POS] |-> h_in1 == a_out;
    endproperty
    a_chain_in1: assert property (p_chain_in1)
        else $error("table A not chained");

    property p_chain_in2;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_SEL_IN2_POS] |-> h_in2 == b_out;
    endproperty
    a_chain_in2: assert property (p_chain_in2)
        else $error("table B not chained");

    // Storage source paths
    property p_store_y_b;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_STORE_Y_POS +: 2] == 2'h1 && $stable(st_r.cfg)
        |=> STORE_Y_O == $past(b_out);
    endproperty
    a_store_y_b: assert property (p_store_y_b)
        else $error("storage Y table B path wrong");

    property p_store_x_comb;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_STORE_X_POS +: 2] == 2'h2 && $stable(st_r.cfg)
        |=> STORE_X_O == $past(h_out);
    endproperty
    a_store_x_comb: assert property (p_store_x_comb)
        else $error("storage X combiner path wrong");

    property p_store_y_a;
        @(posedge CLK_I) disable iff (!RESETN_I)
        st_r.cfg[`CFG_STORE_Y_POS +: 2] == 2'h0 && $stable(st_r.cfg)
        |=> STORE_Y_O == $past(a_out);
    endproperty
    a_store_y_a: assert property (p_store_y_a)
        else $error("storage Y table A path wrong");

    c_master_load: cover property (@(posedge CLK_I) CFG_FETCH_O ##[1:200] CFG_DONE_O);
    c_slave_load: cover property (@(posedge CLK_I)
        st_r.state == LOAD_SHIFT && CFG_EXTERNAL_I ##[1:200] CFG_DONE_O);
    c_x_combiner: cover property (@(posedge CLK_I) st_r.cfg[`CFG_OUT_X_POS] && OUT_X_O);
    c_three_funcs: cover property (@(posedge CLK_I)
        !st_r.cfg[`CFG_OUT_X_POS] && st_r.cfg[`CFG_OUT_Y_POS]
        && st_r.cfg[`CFG_STORE_Y_POS +: 2] == 2'h1);
endmodule : logic_cell

/* verif/cfg_memory_model.sv */
`timescale 1ns/1ns
module cfg_memory_model (
    input wire logic clk_i,
    input wire logic fetch_i,
    input wire logic slow_i,
    input wire logic [47:0] image_i,
    output logic data_o,
    output logic valid_o
);
    int idx = 0;
    logic gap = 1'b0;
    initial begin
        data_o = 1'b0;
        valid_o = 1'b0;
    end
    always @(posedge clk_i) begin
        gap <= slow_i & ~gap;
        if (fetch_i && idx < 48 && !(slow_i && gap)) begin
            data_o <= image_i[idx];
            valid_o <= 1'b1;
            idx <= idx + 1;
        end else begin
            // Line is not held between bits
            valid_o <= 1'b0;
            data_o <= ~data_o;
            if (!fetch_i) begin
                idx <= 0;
            end
        end
    end
endmodule : cfg_memory_model

/* verif/logic_cell_function_generators_tb.sv */
`timescale 1ns/1ns
module logic_cell_function_generators_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic load = 1'b0, ext = 1'b0, tb_data = 1'b0, tb_valid = 1'b0, slow = 1'b0;
    logic pc = 1'b0, c1 = 1'b0, d = 1'b0;
    logic [3:0] a = 4'h0, b = 4'h0;
    logic [47:0] image = 48'h0;
    logic mem_data, mem_valid, fetch, done, out_x, out_y, st_x, st_y;
    int error_cnt = 0;
    int n_tests = 0;
    initial begin
        forever #4 clk = ~clk;
    end
    cfg_memory_model mem (.clk_i(clk), .fetch_i(fetch), .slow_i(slow), .image_i(image),
        .data_o(mem_data), .valid_o(mem_valid));
    logic_cell DUT (.CLK_I(clk), .RESETN_I(resetn), .CFG_LOAD_I(load), .CFG_EXTERNAL_I(ext),
        .CFG_DATA_I(ext ? tb_data : mem_data), .CFG_VALID_I(ext ? tb_valid : mem_valid),
        .TABLE_A_INPUTS_I(a), .TABLE_B_INPUTS_I(b), .PRESET_CLEAR_LINE_I(pc),
        .COMBINER_INPUT_ONE_I(c1), .DIRECT_IN_I(d), .CFG_FETCH_O(fetch), .CFG_DONE_O(done),
        .OUT_X_O(out_x), .OUT_Y_O(out_y), .STORE_X_O(st_x), .STORE_Y_O(st_y));
    task chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task load_cfg(input logic [47:0] img, input logic external, input logic stall);
        int k;
        @(posedge clk);
        image <= img;
        ext <= external;
        slow <= stall;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        if (external) begin
            for (k = 0; k < 48; k++) begin
                tb_valid <= 1'b1;
                tb_data <= img[k];
                @(posedge clk);
            end
            tb_valid <= 1'b0;
            tb_data <= ~img[47];
            @(negedge clk);
            chk("slave fetch", 1'b0, fetch);
        end else begin
            @(negedge clk);
            chk("fetch", 1'b1, fetch);
        end
        for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk);
        chk("load done", 1'b1, done);
    endtask : load_cfg
    // Vector bits: a=v[3:0], b=v[7:4], preset/clear=v[8]
    task apply(input logic [8:0] v);
        @(posedge clk);
        a <= v[3:0];
        b <= v[7:4];
        pc <= v[8];
        c1 <= v[1] ^ v[8];
        d <= v[2] ^ v[6];
        @(posedge clk);
        @(negedge clk);
    endtask : apply
    task three_functions;
        logic [8:0] v;
        load_cfg({2'h1, 2'h3, 4'h8, 8'h96, 16'h8000, 16'h0002}, 1'b1, 1'b0);
        for (int i = 0; i < 512; i += 13) begin
            v = 9'(i);
            apply(v);
            chk("out x", v[3:0] == 4'h1, out_x);
            chk("out y", v[1] ^ v[2] ^ v[6], out_y);
            chk("store x", v[2] ^ v[6], st_x);
            chk("store y", &v[7:4], st_y);
        end
    endtask : three_functions
    task reset_midrun;
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk("reset done", 1'b0, done);
        chk("reset fetch", 1'b0, fetch);
        apply(9'h0f1);
        chk("reset out x", 1'b0, out_x);
        chk("reset out y", 1'b0, out_y);
        chk("reset store x", 1'b0, st_x);
        chk("reset store y", 1'b0, st_y);
    endtask : reset_midrun
    task parity_chain;
        logic [8:0] v;
        load_cfg({2'h0, 2'h2, 4'h7, 8'h96, 16'h6996, 16'h6996}, 1'b0, 1'b1);
        for (int i = 0; i < 512; i += 11) begin
            v = 9'(i);
            apply(v);
            chk("out x", ^v, out_x);
            chk("out y", ^v[7:4], out_y);
            chk("store x", ^v, st_x);
            chk("store y", ^v[3:0], st_y);
        end
    endtask : parity_chain
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        three_functions();
        reset_midrun();
        parity_chain();
        complete_run();
    end
    initial begin
        #(5000 * 8);
        error_cnt++;
        complete_run();
    end
endmodule : logic_cell_function_generators_tb
